// ### logic/axpd_pkg.sv
package axpd_pkg;

   // ----------------------------------------------------------------
   // Object indices and sub-entries
   // ----------------------------------------------------------------
   localparam int unsigned NUM_AXES = 16;
   localparam logic [15:0] IDX_IO_STATUS = 16'h2400;
   localparam logic [15:0] IDX_IO_CMD = 16'h2600;
   localparam logic [15:0] IDX_REG_CMD = 16'h2800;
   localparam logic [15:0] IDX_REG_RSP = 16'h2900;
   localparam logic [7:0] SUB_COUNT = 8'h00;
   localparam logic [7:0] SUB_FLAGS_LOW = 8'h01;
   localparam logic [7:0] SUB_FLAGS_HIGH = 8'h02;
   localparam logic [7:0] SUB_RESERVED = 8'h01;
   localparam logic [7:0] SUB_CODE = 8'h02;
   localparam logic [7:0] SUB_VALUE = 8'h03;
   localparam logic [7:0] SUB_EXEC = 8'h04;
   localparam logic [7:0] IO_SUB_ENTRIES = 8'h02;
   localparam logic [7:0] REG_SUB_ENTRIES = 8'h04;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int unsigned EXEC_BIT = 0;
   localparam int unsigned STAT_ACK_BIT = 0;
   localparam int unsigned STAT_FAIL_BIT = 1;
   localparam int unsigned STAT_AXIS_ERR_BIT = 2;
   localparam logic [15:0] RST_FLAGS = 16'h0000;
   localparam logic [7:0] RST_RESERVED = 8'h00;
   localparam logic [15:0] RST_CODE = 16'h0000;
   localparam logic [31:0] RST_VALUE = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_ISSUE = 3'h2,
      ST_WAIT = 3'h4
   } axpd_state_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [15:0] index;
      logic [7:0] sub;
      logic [31:0] wdata;
   } axpd_obj_req_t;

   typedef struct packed {
      logic valid;
      logic error;
      logic [31:0] rdata;
   } axpd_obj_rsp_t;

   typedef struct packed {
      logic valid;
      logic [3:0] axis;
      logic [15:0] code;
      logic [31:0] value;
   } axpd_ser_req_t;

   typedef struct packed {
      logic valid;
      logic fail;
      logic axis_err;
      logic [31:0] value;
   } axpd_ser_rsp_t;

   typedef struct packed {
      logic valid;
      logic [3:0] axis;
      logic [15:0] flags;
   } axpd_io_status_t;

   typedef struct packed {
      logic en;
      logic [7:0] sub;
      logic [31:0] data;
   } axpd_chan_wr_t;

   typedef struct packed {
      logic exec;
      logic [7:0] reserved;
      logic [15:0] code;
      logic [31:0] value;
      logic pending;
      logic [15:0] cap_code;
      logic [31:0] cap_value;
      logic ack;
      logic fail;
      logic axis_err;
      logic [15:0] rsp_code;
      logic [31:0] rsp_value;
   } axpd_chan_t;

endpackage

// ### logic/axpd_chan.sv
`timescale 1ns/1ps
module axpd_chan (
   input wire logic clk_i,                       // System clock
   input wire logic rst_n_i,                     // Synchronous reset, active low
   input wire axpd_pkg::axpd_chan_wr_t wr_i,     // Decoded command object write
   input wire logic done_i,                      // Serial transaction finished
   input wire axpd_pkg::axpd_ser_rsp_t rsp_i,    // Serial transaction result
   output axpd_pkg::axpd_chan_t view_o           // Channel state
);

   axpd_pkg::axpd_chan_t s;
   axpd_pkg::axpd_chan_t next_s;
   logic rise;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_s = s;
      rise = 1'b0;
      if (wr_i.en) begin
         case (wr_i.sub)
            axpd_pkg::SUB_RESERVED: begin
               next_s.reserved = wr_i.data[7:0];
            end
            axpd_pkg::SUB_CODE: begin
               next_s.code = wr_i.data[15:0];
            end
            axpd_pkg::SUB_VALUE: begin
               next_s.value = wr_i.data;
            end
            axpd_pkg::SUB_EXEC: begin
               // Only bit 0 is kept; upper bits are dropped
               next_s.exec = wr_i.data[axpd_pkg::EXEC_BIT];
               rise = wr_i.data[axpd_pkg::EXEC_BIT] & ~s.exec;
            end
            default: begin
               next_s = s;
            end
         endcase
      end
      // Launch once per rising edge, never while answered or busy
      if (rise && !s.ack && !s.pending) begin
         next_s.pending = 1'b1;
         next_s.cap_code = next_s.code;
         next_s.cap_value = next_s.value;
      end
      // Acknowledge clears once the request bit is low again
      if (!next_s.exec) begin
         next_s.ack = 1'b0;
         next_s.fail = 1'b0;
         next_s.axis_err = 1'b0;
      end
      // Completion wins over a clear in the same cycle
      if (done_i && s.pending) begin
         next_s.pending = 1'b0;
         next_s.ack = 1'b1;
         next_s.fail = rsp_i.fail;
         next_s.axis_err = rsp_i.axis_err;
         next_s.rsp_code = s.cap_code;
         next_s.rsp_value = rsp_i.value;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign view_o = s;

endmodule

// ### logic/axpd_top.sv
// Functional notes
// - Each axis has a read-only status object at 2400h+axis, sub 1 flags 0-7, sub 2 flags 8-15.
// - Each axis has a read-write command object at 2600h+axis, sub 1 flags 0-7, sub 2 flags 8-15.
// - Sub-entry 0 of each remote I/O object reads back 2 and cannot be written.
// - Remote register command objects sit at 2800h to 280Fh, one per axis in order.
// - Remote register response objects sit at 2900h to 290Fh, one per axis in order.
// - Command objects are writable as master-to-device process data.
// - Response objects are readable as device-to-master process data.
// - A command object reports 4 entries: reserved byte, 16-bit code, signed 32-bit value, trigger byte.
// - Only bit 0 of the trigger byte matters; 1 asks for execution, 0 for none.
// - An executed command becomes one serial request to the drive on that axis.
// - The response status byte has acknowledge in bit 0, failure in bit 1, axis error in bit 2, bit 3 zero.
// - Trigger back at 0 clears acknowledge and the failure flag.
// - An undefined code or out-of-range value sets failure together with acknowledge.
`timescale 1ns/1ps
module axpd_top (
   input wire logic clk_i,                              // System clock, 20 MHz
   input wire logic rst_n_i,                            // Synchronous reset, active low
   input wire axpd_pkg::axpd_obj_req_t obj_req_i,       // Object access from fieldbus side
   output axpd_pkg::axpd_obj_rsp_t obj_rsp_o,           // Object access answer
   input wire axpd_pkg::axpd_io_status_t io_status_i,   // Output flag update from drive side
   output logic [15:0][15:0] axis_input_flags_o,        // Input flags per axis
   output axpd_pkg::axpd_ser_req_t ser_req_o,           // Serial transaction request
   input wire logic ser_req_ready_i,                    // Serial side takes request
   input wire axpd_pkg::axpd_ser_rsp_t ser_rsp_i        // Serial transaction result
);

   // ----------------------------------------------------------------
   // Types and helpers
   // ----------------------------------------------------------------
   typedef struct packed {
      axpd_pkg::axpd_state_t st;
      logic [3:0] cur_axis;
      axpd_pkg::axpd_ser_req_t ser_req;
      axpd_pkg::axpd_obj_rsp_t obj_rsp;
      logic [15:0][15:0] in_flags;
      logic [15:0][15:0] out_flags;
   } axpd_top_state_t;

   // True when an index falls in the 16-entry block at base
   function automatic logic idx_hit(input logic [15:0] idx, input logic [15:0] base);
      idx_hit = (idx[15:4] == base[15:4]);
   endfunction

   // Lowest pending axis; bit 4 flags that one was found
   function automatic logic [4:0] first_pending(input logic [15:0] p);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 15; i >= 0; i--) begin
         if (p[i]) begin
            r = {1'b1, 4'(i)};
         end
      end
      first_pending = r;
   endfunction

   axpd_top_state_t s;
   axpd_top_state_t next_s;
   axpd_pkg::axpd_chan_wr_t chan_wr [16];
   axpd_pkg::axpd_chan_t chan_view [16];
   logic [15:0] chan_done;
   logic [15:0] pend_vec;
   logic [3:0] req_axis;
   logic [4:0] pick;

   assign req_axis = obj_req_i.index[3:0];

   // ----------------------------------------------------------------
   // Per-axis remote register channels
   // ----------------------------------------------------------------
   for (genvar g = 0; g < 16; g++) begin : g_chan
      axpd_chan u_chan (
         .clk_i(clk_i),
         .rst_n_i(rst_n_i),
         .wr_i(chan_wr[g]),
         .done_i(chan_done[g]),
         .rsp_i(ser_rsp_i),
         .view_o(chan_view[g])
      );
      assign pend_vec[g] = chan_view[g].pending;
   end

   // Route command object writes and completions to one channel
   always_comb begin
      for (int a = 0; a < 16; a++) begin
         chan_wr[a].en = obj_req_i.valid && obj_req_i.write && idx_hit(obj_req_i.index, axpd_pkg::IDX_REG_CMD)
                         && (req_axis == 4'(a)) && (obj_req_i.sub != axpd_pkg::SUB_COUNT);
         chan_wr[a].sub = obj_req_i.sub;
         chan_wr[a].data = obj_req_i.wdata;
         chan_done[a] = (s.st == axpd_pkg::ST_WAIT) && ser_rsp_i.valid && (s.cur_axis == 4'(a));
      end
   end

   assign pick = first_pending(pend_vec);

   // ----------------------------------------------------------------
   // Object access, flag storage and serial sequencing
   // ----------------------------------------------------------------
   always_comb begin
      next_s = s;
      next_s.obj_rsp.valid = 1'b0;
      next_s.obj_rsp.error = 1'b0;

      // Output flags arrive from the drive side
      if (io_status_i.valid) begin
         next_s.out_flags[io_status_i.axis] = io_status_i.flags;
      end

      // Object access; answer stands one cycle after the request
      if (obj_req_i.valid) begin
         next_s.obj_rsp.valid = 1'b1;
         next_s.obj_rsp.rdata = 32'h0000_0000;
         if (idx_hit(obj_req_i.index, axpd_pkg::IDX_IO_STATUS)) begin
            // Status object is read-only in all entries
            next_s.obj_rsp.error = obj_req_i.write;
            case (obj_req_i.sub)
               axpd_pkg::SUB_COUNT: begin
                  next_s.obj_rsp.rdata = {24'h000000, axpd_pkg::IO_SUB_ENTRIES};
               end
               axpd_pkg::SUB_FLAGS_LOW: begin
                  next_s.obj_rsp.rdata = {24'h000000, s.out_flags[req_axis][7:0]};
               end
               axpd_pkg::SUB_FLAGS_HIGH: begin
                  next_s.obj_rsp.rdata = {24'h000000, s.out_flags[req_axis][15:8]};
               end
               default: begin
                  next_s.obj_rsp.error = 1'b1;
               end
            endcase
         end else if (idx_hit(obj_req_i.index, axpd_pkg::IDX_IO_CMD)) begin
            case (obj_req_i.sub)
               axpd_pkg::SUB_COUNT: begin
                  next_s.obj_rsp.error = obj_req_i.write;
                  next_s.obj_rsp.rdata = {24'h000000, axpd_pkg::IO_SUB_ENTRIES};
               end
               axpd_pkg::SUB_FLAGS_LOW: begin
                  if (obj_req_i.write) begin
                     next_s.in_flags[req_axis][7:0] = obj_req_i.wdata[7:0];
                  end
                  next_s.obj_rsp.rdata = {24'h000000, s.in_flags[req_axis][7:0]};
               end
               axpd_pkg::SUB_FLAGS_HIGH: begin
                  if (obj_req_i.write) begin
                     next_s.in_flags[req_axis][15:8] = obj_req_i.wdata[7:0];
                  end
                  next_s.obj_rsp.rdata = {24'h000000, s.in_flags[req_axis][15:8]};
               end
               default: begin
                  next_s.obj_rsp.error = 1'b1;
               end
            endcase
         end else if (idx_hit(obj_req_i.index, axpd_pkg::IDX_REG_CMD)) begin
            // Writes themselves land in the channel; here only readback
            case (obj_req_i.sub)
               axpd_pkg::SUB_COUNT: begin
                  next_s.obj_rsp.error = obj_req_i.write;
                  next_s.obj_rsp.rdata = {24'h000000, axpd_pkg::REG_SUB_ENTRIES};
               end
               axpd_pkg::SUB_RESERVED: begin
                  next_s.obj_rsp.rdata = {24'h000000, chan_view[req_axis].reserved};
               end
               axpd_pkg::SUB_CODE: begin
                  next_s.obj_rsp.rdata = {16'h0000, chan_view[req_axis].code};
               end
               axpd_pkg::SUB_VALUE: begin
                  next_s.obj_rsp.rdata = chan_view[req_axis].value;
               end
               axpd_pkg::SUB_EXEC: begin
                  next_s.obj_rsp.rdata = {31'h0000_0000, chan_view[req_axis].exec};
               end
               default: begin
                  next_s.obj_rsp.error = 1'b1;
               end
            endcase
         end else if (idx_hit(obj_req_i.index, axpd_pkg::IDX_REG_RSP)) begin
            // Response object is read-only, fed to the master as process data
            next_s.obj_rsp.error = obj_req_i.write;
            case (obj_req_i.sub)
               axpd_pkg::SUB_COUNT: begin
                  next_s.obj_rsp.rdata = {24'h000000, axpd_pkg::REG_SUB_ENTRIES};
               end
               axpd_pkg::SUB_RESERVED: begin
                  next_s.obj_rsp.rdata = 32'h0000_0000;
               end
               axpd_pkg::SUB_CODE: begin
                  next_s.obj_rsp.rdata = {16'h0000, chan_view[req_axis].rsp_code};
               end
               axpd_pkg::SUB_VALUE: begin
                  next_s.obj_rsp.rdata = chan_view[req_axis].rsp_value;
               end
               axpd_pkg::SUB_EXEC: begin
                  // Bit 3 and above stay zero
                  next_s.obj_rsp.rdata = 32'h0000_0000;
                  next_s.obj_rsp.rdata[axpd_pkg::STAT_ACK_BIT] = chan_view[req_axis].ack;
                  next_s.obj_rsp.rdata[axpd_pkg::STAT_FAIL_BIT] = chan_view[req_axis].fail;
                  next_s.obj_rsp.rdata[axpd_pkg::STAT_AXIS_ERR_BIT] = chan_view[req_axis].axis_err;
               end
               default: begin
                  next_s.obj_rsp.error = 1'b1;
               end
            endcase
         end else begin
            // Unmapped index answers with an error and zero data
            next_s.obj_rsp.error = 1'b1;
         end
      end

      // One serial transaction at a time; fixed priority by axis number,
      // cheap but a busy low axis can delay higher ones
      case (s.st)
         axpd_pkg::ST_IDLE: begin
            if (pick[4]) begin
               next_s.cur_axis = pick[3:0];
               next_s.ser_req.valid = 1'b1;
               next_s.ser_req.axis = pick[3:0];
               next_s.ser_req.code = chan_view[pick[3:0]].cap_code;
               next_s.ser_req.value = chan_view[pick[3:0]].cap_value;
               next_s.st = axpd_pkg::ST_ISSUE;
            end
         end
         axpd_pkg::ST_ISSUE: begin
            if (ser_req_ready_i) begin
               next_s.ser_req.valid = 1'b0;
               next_s.st = axpd_pkg::ST_WAIT;
            end
         end
         axpd_pkg::ST_WAIT: begin
            // Result goes to the channel through its done strobe
            if (ser_rsp_i.valid) begin
               next_s.st = axpd_pkg::ST_IDLE;
            end
         end
         default: begin
            next_s.st = axpd_pkg::ST_IDLE;
            next_s.ser_req.valid = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s <= '0;
         s.st <= axpd_pkg::ST_IDLE;
         s.in_flags <= {16{axpd_pkg::RST_FLAGS}};
         s.out_flags <= {16{axpd_pkg::RST_FLAGS}};
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all straight from flip-flops
   // ----------------------------------------------------------------
   assign obj_rsp_o = s.obj_rsp;
   assign ser_req_o = s.ser_req;
   assign axis_input_flags_o = s.in_flags;

endmodule

// ### verif/axpd_drive_model.sv
`timescale 1ns/1ps
module axpd_drive_model (
   input wire logic clk_i,                       // System clock
   input wire logic rst_n_i,                     // Synchronous reset, active low
   input wire logic slow_i,                      // Stretch accept and answer
   input wire axpd_pkg::axpd_ser_req_t req_i,    // Request from the gateway
   output logic ready_o,                         // Request taken this cycle
   output axpd_pkg::axpd_ser_rsp_t rsp_o         // Transaction result
);
   // Stand-in undefined code of the drive
   localparam logic [15:0] BAD_CODE = 16'h0001;
   logic busy;
   logic bad;
   logic aerr;
   logic [7:0] cnt;
   logic [31:0] val;

   // ----------------------------------------------
   // Accept one request, answer after a delay
   // ----------------------------------------------
   // Idle result fields flip each cycle so a stale value is never mistaken for an answer
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         busy <= 1'b0;
         bad <= 1'b0;
         aerr <= 1'b0;
         val <= 32'h0;
         cnt <= 8'h00;
         ready_o <= 1'b0;
         rsp_o <= '0;
      end else if (!busy) begin
         rsp_o <= {1'b0, ~rsp_o.fail, ~rsp_o.axis_err, ~rsp_o.value};
         cnt <= cnt + 8'h01;
         ready_o <= req_i.valid && !ready_o && (!slow_i || cnt[2]);
         if (req_i.valid && ready_o) begin
            busy <= 1'b1;
            cnt <= 8'h00;
            ready_o <= 1'b0;
            val <= req_i.value + 32'h1;
            // Axis 14 stands in for an absent drive address
            aerr <= req_i.axis == 4'he;
            bad <= req_i.code == BAD_CODE || $signed(req_i.value) > 8388607 || $signed(req_i.value) < -8388608;
         end
      end else begin
         cnt <= cnt + 8'h01;
         if (cnt == (slow_i ? 8'h14 : 8'h02)) begin
            busy <= 1'b0;
            rsp_o <= {1'b1, bad, aerr, val};
         end
      end
   end
endmodule

// ### verif/axpd_properties.sv
`timescale 1ns/1ps
module axpd_properties (
   input wire logic clk_i,                       // System clock
   input wire logic rst_n_i,                     // Synchronous reset, active low
   input wire axpd_pkg::axpd_obj_req_t obj_req_i, // Object access
   input wire axpd_pkg::axpd_obj_rsp_t obj_rsp_o, // Object answer
   input wire logic [15:0][15:0] axis_input_flags_o, // Input flags per axis
   input wire axpd_pkg::axpd_ser_req_t ser_req_o, // Serial request
   input wire logic ser_req_ready_i              // Serial side takes request
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   logic acc;
   logic wr;
   logic rd;
   logic [11:0] base;

   // ----------------------------------------------
   // Access decode
   // ----------------------------------------------
   assign acc = obj_req_i.valid;
   assign wr = acc && obj_req_i.write;
   assign rd = acc && !obj_req_i.write;
   assign base = obj_req_i.index[15:4];

   // ----------------------------------------------
   // Object access answers
   // ----------------------------------------------
   a_answer_next: assert property (acc |=> obj_rsp_o.valid) else $error("access not answered");
   a_answer_only: assert property (!acc |=> !obj_rsp_o.valid) else $error("answer without access");
   a_status_ro: assert property (wr && base == 12'h240 |=> obj_rsp_o.error) else $error("status written");
   a_rsp_ro: assert property (wr && base == 12'h290 |=> obj_rsp_o.error) else $error("response written");
   a_io_count: assert property (rd && (base == 12'h240 || base == 12'h260) && obj_req_i.sub == 8'h00
      |=> obj_rsp_o.rdata == 32'h2 && !obj_rsp_o.error) else $error("io entry count wrong");
   a_reg_count: assert property (rd && base == 12'h280 && obj_req_i.sub == 8'h00
      |=> obj_rsp_o.rdata == 32'h4) else $error("command entry count wrong");
   a_flags_low: assert property (wr && base == 12'h260 && obj_req_i.sub == 8'h01
      |=> axis_input_flags_o[$past(obj_req_i.index[3:0])][7:0] == $past(obj_req_i.wdata[7:0]))
      else $error("input flags not stored");
   a_execute_request_bit0: assert property (rd && base == 12'h280 && obj_req_i.sub == 8'h04
      |=> obj_rsp_o.rdata[31:1] == 31'h0) else $error("trigger upper bits set");
   a_status_bits: assert property (rd && base == 12'h290 && obj_req_i.sub == 8'h04
      |=> obj_rsp_o.rdata[31:3] == 29'h0) else $error("status upper bits set");
   a_unmapped_err: assert property (acc && obj_req_i.index[15:12] != 4'h2
      |=> obj_rsp_o.error && obj_rsp_o.rdata == 32'h0) else $error("unmapped not refused");

   // ----------------------------------------------
   // Serial request handshake
   // ----------------------------------------------
   a_req_held: assert property (ser_req_o.valid && !ser_req_ready_i |=> ser_req_o.valid && $stable(ser_req_o))
      else $error("request changed while waiting");
   a_req_once: assert property (ser_req_o.valid && ser_req_ready_i |=> !ser_req_o.valid)
      else $error("request repeated");
endmodule

bind axpd_top axpd_properties axpd_properties_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .obj_req_i(obj_req_i),
   .obj_rsp_o(obj_rsp_o), .axis_input_flags_o(axis_input_flags_o), .ser_req_o(ser_req_o),
   .ser_req_ready_i(ser_req_ready_i));

// ### verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic slow = 1'b0;
   axpd_pkg::axpd_obj_req_t obj_req = '0;
   axpd_pkg::axpd_obj_rsp_t obj_rsp;
   axpd_pkg::axpd_io_status_t io_status = '0;
   logic [15:0][15:0] in_flags;
   axpd_pkg::axpd_ser_req_t ser_req;
   axpd_pkg::axpd_ser_req_t last_req = '0;
   logic ser_ready;
   axpd_pkg::axpd_ser_rsp_t ser_rsp;
   logic [31:0] rd;
   int n_mismatch = 0;
   int check_count = 0;
   int req_count = 0;

   always #25 clk_i = ~clk_i;

   axpd_top axpd_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .obj_req_i(obj_req), .obj_rsp_o(obj_rsp),
      .io_status_i(io_status), .axis_input_flags_o(in_flags), .ser_req_o(ser_req),
      .ser_req_ready_i(ser_ready), .ser_rsp_i(ser_rsp));
   axpd_drive_model axpd_drive_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .slow_i(slow), .req_i(ser_req),
      .ready_o(ser_ready), .rsp_o(ser_rsp));

   // Record every request the drive accepts
   always @(posedge clk_i) begin
      if (rst_n_i && ser_req.valid && ser_ready) begin
         req_count <= req_count + 1;
         last_req <= ser_req;
      end
   end

   // ----------------------------------------------
   // Compare and access tasks
   // ----------------------------------------------
   task automatic chk_data(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_flag(input string what, input logic exp, input logic got);
      chk_data(what, {31'h0, exp}, {31'h0, got});
   endtask

   // One access: answer is registered on the edge that takes it and checked 1 ns later
   task automatic access(input logic w, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd);
      @(posedge clk_i);
      obj_req <= '{1'b1, w, idx, sub, wd};
      @(posedge clk_i);
      obj_req.valid <= 1'b0;
      #1;
      chk_flag("answer valid", 1'b1, obj_rsp.valid);
   endtask

   task automatic put(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd, input logic err);
      access(1'b1, idx, sub, wd);
      chk_flag("write error", err, obj_rsp.error);
   endtask

   task automatic get(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp, input logic err);
      access(1'b0, idx, sub, 32'h0);
      chk_flag("read error", err, obj_rsp.error);
      chk_data("read data", exp, obj_rsp.rdata);
   endtask

   // Polls the status byte; bounded so a lost answer cannot hang the run
   task automatic wait_ack(input logic [3:0] a, input logic [7:0] exp);
      int n;
      n = 0;
      rd = 32'h0;
      while (rd[0] !== 1'b1 && n < 60) begin
         access(1'b0, 16'h2900 + {12'h0, a}, 8'h04, 32'h0);
         rd = obj_rsp.rdata;
         n++;
      end
      chk_data("status byte", {24'h0, exp}, rd);
   endtask

   task automatic run_cmd(input logic [3:0] a, input logic [15:0] code, input logic [31:0] val,
         input logic [7:0] st);
      logic [15:0] ci;
      logic [15:0] ri;
      int k;
      ci = 16'h2800 + {12'h0, a};
      ri = 16'h2900 + {12'h0, a};
      k = req_count;
      get(ri, 8'h04, 32'h0, 1'b0);
      put(ci, 8'h02, {16'h0, code}, 1'b0);
      put(ci, 8'h03, val, 1'b0);
      put(ci, 8'h04, 32'h1, 1'b0);
      put(ci, 8'h02, 32'h5555, 1'b0);
      wait_ack(a, st);
      chk_data("drive axis", {28'h0, a}, {28'h0, last_req.axis});
      chk_data("drive code", {16'h0, code}, {16'h0, last_req.code});
      chk_data("drive value", val, last_req.value);
      get(ri, 8'h02, {16'h0, code}, 1'b0);
      get(ri, 8'h03, val + 32'h1, 1'b0);
      put(ci, 8'h04, 32'hff, 1'b0);
      get(ri, 8'h04, {24'h0, st}, 1'b0);
      get(ci, 8'h04, 32'h1, 1'b0);
      put(ci, 8'h04, 32'h0, 1'b0);
      get(ri, 8'h04, 32'h0, 1'b0);
      chk_data("request count", k + 1, req_count);
      $display("test command axis %0d done", a);
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------------
   // Test sequence
   // ----------------------------------------------
   initial begin
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      for (int a = 0; a < 16; a++) begin
         get(16'h2400 + a[15:0], 8'h00, 32'h2, 1'b0);
         get(16'h2600 + a[15:0], 8'h00, 32'h2, 1'b0);
         get(16'h2800 + a[15:0], 8'h00, 32'h4, 1'b0);
         get(16'h2900 + a[15:0], 8'h00, 32'h4, 1'b0);
         get(16'h2400 + a[15:0], 8'h01, 32'h0, 1'b0);
         put(16'h2600 + a[15:0], 8'h01, {24'h0, a[7:0] ^ 8'h5a}, 1'b0);
         put(16'h2600 + a[15:0], 8'h02, {24'h0, a[7:0] ^ 8'ha5}, 1'b0);
      end
      for (int a = 0; a < 16; a++) begin
         chk_data("input flags", {16'h0, a[7:0] ^ 8'ha5, a[7:0] ^ 8'h5a}, {16'h0, in_flags[a]});
         get(16'h2600 + a[15:0], 8'h02, {24'h0, a[7:0] ^ 8'ha5}, 1'b0);
      end
      $display("test object map done");
      put(16'h2603, 8'h00, 32'h7, 1'b1);
      put(16'h2403, 8'h01, 32'hff, 1'b1);
      put(16'h2903, 8'h04, 32'h1, 1'b1);
      get(16'h3000, 8'h00, 32'h0, 1'b1);
      get(16'h2400, 8'h03, 32'h0, 1'b1);
      @(posedge clk_i);
      io_status <= '{1'b1, 4'h5, 16'ha55a};
      @(posedge clk_i);
      io_status.valid <= 1'b0;
      get(16'h2405, 8'h01, 32'h5a, 1'b0);
      get(16'h2405, 8'h02, 32'ha5, 1'b0);
      get(16'h2404, 8'h01, 32'h0, 1'b0);
      $display("test refusals and status done");
      run_cmd(4'h0, 16'h0200, 32'd1000, 8'h01);
      run_cmd(4'hf, 16'h1200, 32'd9999999, 8'h03);
      run_cmd(4'h7, 16'h0001, 32'h0, 8'h03);
      run_cmd(4'he, 16'h0200, 32'd5, 8'h05);
      slow <= 1'b1;
      run_cmd(4'h9, 16'h1240, 32'hfff0_0000, 8'h01);
      put(16'h2809, 8'h04, 32'h1, 1'b0);
      put(16'h2802, 8'h04, 32'h1, 1'b0);
      wait_ack(4'h9, 8'h01);
      wait_ack(4'h2, 8'h01);
      chk_data("request count", 32'd7, req_count);
      $display("test two channels done");
      report_and_stop();
   end

   // Cut a hang short well beyond the expected run length
   initial begin
      #2000000;
      n_mismatch++;
      report_and_stop();
   end
endmodule
